// ==== fdpt_top.sv ====
// Discovery parameter table responder: link slave, table store, byte FIFO and registers
`timescale 1ns/100ps

// ------------------------------------------------------------
// Byte FIFO between the table store and the output shifter
// ------------------------------------------------------------
module fdpt_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             flush,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];   // Storage words
   logic [AW-1:0]    wr_ptr_reg;    // Next slot to fill
   logic [AW-1:0]    rd_ptr_reg;    // Next slot to drain
   logic [AW:0]      count_reg;     // Words held
   logic             push;
   logic             pop;

   assign in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data  = mem[rd_ptr_reg];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Storage write, no reset needed for data
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and fill level; flush empties at once
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else if (flush) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + AW'(1);
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + AW'(1);
         end
         if (push && !pop) begin
            count_reg <= count_reg + (AW+1)'(1);
         end else if (pop && !push) begin
            count_reg <= count_reg - (AW+1)'(1);
         end
      end
   end
endmodule

// ------------------------------------------------------------
// Top: serial link slave returning the parameter table
// ------------------------------------------------------------
// What this block does
// - Byte 30h low bits 01b; opcode 20h at 31h
// - Bit 2 reads 1: large write granularity
// - Bit 3 reads 0: no volatile enable needed
// - Bit 4 reads 0, selecting opcode 50h
// - Byte 30h top bits fixed at 111b
// - Bits 16 and 20 report 1-1-2, 1-2-2 reads
// - Address field bits 18:17 read 00b
// - Bit 19 reads 0: no DTR clocking
// - 1-4-4 read: wait 4, mode 010b, EBh
// - 1-1-4 read: wait 8, mode 000b, 6Bh
// - Bits 21 and 22 flag 1-4-4, 1-1-4 reads; a zero mode field still means supported
// - Opcode 5Ah, three address, dummy, data; CS ends
// - Header pointer gives 30h for table start
module fdpt_top
   import fdpt_pkg::*;
#(
   parameter logic [7:0] VENDOR_ID = 8'hA5   // Second header owner code, value arbitrary
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Serial link pins
   input  wire logic        cs_n,
   input  wire logic        sclk,
   input  wire logic        si,
   output logic             so,
   output logic             so_oe,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata
);

   // ------------------------------------------------------------
   // Table contents
   // ------------------------------------------------------------
   // Only bytes 00h..3Bh carry data; everything else reads as ones.
   function automatic logic [7:0] table_byte(input logic [23:0] a);
      logic [7:0] b;
      b = BYTE_UNUSED;
      if (a[23:8] == TBL_HIGH_ZERO) begin
         case (a[7:0])
            8'h00: b = HDR_SIG0;
            8'h01: b = HDR_SIG1;
            8'h02: b = HDR_SIG2;
            8'h03: b = HDR_SIG3;
            8'h04: b = HDR_REV_MINOR;
            8'h05: b = HDR_REV_MAJOR;
            8'h06: b = HDR_NUM_HDRS;
            8'h08: b = HDR_STD_ID;
            8'h09: b = HDR_REV_MINOR;
            8'h0A: b = HDR_REV_MAJOR;
            8'h0B: b = HDR_BASIC_LEN;
            8'h0C: b = PARAMETER_TABLE_POINTER;
            8'h0D: b = HDR_ZERO;
            8'h0E: b = HDR_ZERO;
            8'h10: b = VENDOR_ID;
            8'h11: b = HDR_REV_MINOR;
            8'h12: b = HDR_REV_MAJOR;
            8'h13: b = HDR_VND_LEN;
            8'h14: b = HDR_VND_PTR;
            8'h15: b = HDR_ZERO;
            8'h16: b = HDR_ZERO;
            // Erase, granularity and status write enable fields
            8'h30: b = {BYTE30_FIXED_TOP,
                        WREN_OPCODE_SEL,
                        WREN_VOL_REQUIRED,
                        WRITE_GRAN_LARGE,
                        ERASE_4K_SUPPORT};
            8'h31: b = ERASE_4K_OPCODE;
            // Fast read support, address width and DTR
            8'h32: b = {BIT_UNUSED,
                        FR_114_SUPPORT,
                        FR_144_SUPPORT,
                        FR_122_SUPPORT,
                        DTR_SUPPORT,
                        ADDR_BYTES_MODE,
                        FR_112_SUPPORT};
            // Wait and mode fields, then opcodes, of the 1-4-4 and 1-1-4 reads
            8'h38: b = {FR_144_MODE, FR_144_WAIT};
            8'h39: b = FR_144_OPCODE;
            8'h3A: b = {FR_114_MODE, FR_114_WAIT};
            8'h3B: b = FR_114_OPCODE;
            default: b = BYTE_UNUSED;
         endcase
      end
      return b;
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic cs_s1, cs_s2;        // Chip select, active low
   logic sclk_s1, sclk_s2;    // Link clock samples
   logic sclk_d;              // Previous synchronised link clock
   logic si_s1, si_s2;        // Serial input

   // Two flops per pin; the first of each is read only by the second
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cs_s1   <= 1'b1;
         cs_s2   <= 1'b1;
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_d  <= 1'b0;
         si_s1   <= 1'b0;
         si_s2   <= 1'b0;
      end else begin
         cs_s1   <= cs_n;
         cs_s2   <= cs_s1;
         sclk_s1 <= sclk;
         sclk_s2 <= sclk_s1;
         sclk_d  <= sclk_s2;
         si_s1   <= si;
         si_s2   <= si_s1;
      end
   end

   logic sclk_rise;           // One-cycle enable on link clock rising edge
   logic sclk_fall;           // One-cycle enable on link clock falling edge
   logic sel;                 // Chip selected
   assign sclk_rise = sclk_s2 & ~sclk_d;
   assign sclk_fall = ~sclk_s2 & sclk_d;
   assign sel       = ~cs_s2;

   // ------------------------------------------------------------
   // Receive side: bit counter, shifter, state
   // ------------------------------------------------------------
   fdpt_state_t state_reg;    // Link sequence state
   logic [2:0]  bit_cnt_reg;  // Bit within current byte
   logic [7:0]  rx_sh_reg;    // Incoming bits
   logic [7:0]  rx_next;      // Byte including the bit now sampled
   logic [1:0]  abyte_reg;    // Address byte index
   logic [15:0] addr_hi_reg;  // First two address bytes
   logic        byte_done;    // Last bit of a byte sampled now
   logic        ctrl_en_reg;  // Software enable for answering

   assign rx_next   = {rx_sh_reg[6:0], si_s2};
   assign byte_done = sel & sclk_rise & (bit_cnt_reg == BIT_LAST);

   // Bit counter restarts with every selection; the input shifter keeps its bits
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bit_cnt_reg <= '0;
         rx_sh_reg   <= '0;
      end else if (!sel) begin
         bit_cnt_reg <= '0;
      end else if (sclk_rise) begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         rx_sh_reg   <= rx_next;
      end
   end

   // Sequence: opcode, three address bytes, dummy byte, then data
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= FDPT_IDLE;
      end else if (!sel) begin
         state_reg <= FDPT_IDLE;
      end else begin
         case (state_reg)
            FDPT_IDLE: begin
               state_reg <= FDPT_CMD;
            end
            FDPT_CMD: begin
               // Any other opcode is left to other parts of the device
               if (byte_done) begin
                  state_reg <= (rx_next == READ_DISCOVERY_TABLE_CMD && ctrl_en_reg) ?
                               FDPT_ADDR : FDPT_IGNORE;
               end
            end
            FDPT_ADDR: begin
               if (byte_done && abyte_reg == ADDR_BYTE_LAST) begin
                  state_reg <= FDPT_DUMMY;
               end
            end
            FDPT_DUMMY: begin
               if (byte_done) begin
                  state_reg <= FDPT_DATA;
               end
            end
            FDPT_DATA: begin
               state_reg <= FDPT_DATA;
            end
            FDPT_IGNORE: begin
               state_reg <= FDPT_IGNORE;
            end
            default: begin
               state_reg <= FDPT_IDLE;
            end
         endcase
      end
   end

   // Address collection, most significant byte first
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         abyte_reg   <= '0;
         addr_hi_reg <= '0;
      end else if (state_reg != FDPT_ADDR) begin
         abyte_reg <= '0;
      end else if (byte_done) begin
         abyte_reg   <= abyte_reg + 2'h1;
         addr_hi_reg <= {addr_hi_reg[7:0], rx_next};
      end
   end

   // ------------------------------------------------------------
   // Table fetch into the FIFO
   // ------------------------------------------------------------
   logic [23:0] ptr_reg;      // Next table address to fetch
   logic        fill_valid;   // Fetch allowed
   logic        fill_ready;   // FIFO has room
   logic [7:0]  fill_data;    // Byte at the fetch address
   logic        drain_valid;  // FIFO holds a byte
   logic        drain_ready;  // Output shifter takes a byte
   logic [7:0]  drain_data;   // Oldest buffered byte
   logic        addr_load;    // Third address byte just arrived

   // Prefetch starts during the dummy byte so data is waiting at its end
   assign addr_load  = byte_done & (state_reg == FDPT_ADDR) & (abyte_reg == ADDR_BYTE_LAST);
   assign fill_valid = sel & ((state_reg == FDPT_DUMMY) | (state_reg == FDPT_DATA));
   assign fill_data  = table_byte(ptr_reg);

   // Fetch pointer; steps only when a byte enters the FIFO
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ptr_reg <= '0;
      end else if (addr_load) begin
         ptr_reg <= {addr_hi_reg, rx_next};
      end else if (fill_valid && fill_ready) begin
         ptr_reg <= ptr_reg + 24'h1;
      end
   end

   // Flushed whenever the chip is deselected so no stale bytes survive
   fdpt_fifo #(
      .WIDTH (8),
      .DEPTH (8)
   ) u_fifo (
      .clk       (clk),
      .rstn      (rstn),
      .flush     (!sel),
      .in_valid  (fill_valid),
      .in_ready  (fill_ready),
      .in_data   (fill_data),
      .out_valid (drain_valid),
      .out_ready (drain_ready),
      .out_data  (drain_data)
   );

   // ------------------------------------------------------------
   // Output shifter, changes on link clock falling edges
   // ------------------------------------------------------------
   logic [7:0] tx_sh_reg;     // Byte being sent, MSB at top
   logic [2:0] tx_cnt_reg;    // Bit position being sent
   logic       tx_load;       // Start of a new output byte

   assign tx_load     = sel & sclk_fall & (state_reg == FDPT_DATA) & (tx_cnt_reg == '0);
   assign drain_ready = tx_load;

   // An empty FIFO sends ones; at 200 MHz against a 48 ns link this cannot occur
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_sh_reg  <= '0;
         tx_cnt_reg <= '0;
      end else if (state_reg != FDPT_DATA) begin
         tx_cnt_reg <= '0;
      end else if (sclk_fall) begin
         tx_cnt_reg <= tx_cnt_reg + 3'h1;
         if (tx_load) begin
            tx_sh_reg <= drain_valid ? drain_data : BYTE_UNUSED;
         end else begin
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b1};
         end
      end
   end

   // Pin drive: serial output only in the data phase
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         so    <= 1'b0;
         so_oe <= 1'b0;
      end else begin
         so_oe <= sel & (state_reg == FDPT_DATA);
         if (sclk_fall && state_reg == FDPT_DATA) begin
            so <= tx_load ? (drain_valid ? drain_data[7] : 1'b1) : tx_sh_reg[6];
         end
      end
   end

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   logic [15:0] done_cnt_reg; // Discovery reads ended in data phase

   // Control: enable for answering the discovery read
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_en_reg <= CTRL_EN_RST;
      end else if (reg_wr && reg_addr == REG_CTRL_OFS) begin
         ctrl_en_reg <= reg_wdata[0];
      end
   end

   // Completed reads; a write of any value clears, a completion at once wins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         done_cnt_reg <= '0;
      end else if (!sel && state_reg == FDPT_DATA) begin
         done_cnt_reg <= done_cnt_reg + 16'h1;
      end else if (reg_wr && reg_addr == REG_COUNT_OFS) begin
         done_cnt_reg <= '0;
      end
   end

   // Read data appear in the cycle after the strobe, zero otherwise
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= RDATA_NONE;
      end else if (reg_rd) begin
         case (reg_addr)
            REG_CTRL_OFS:   reg_rdata <= {31'h0, ctrl_en_reg};
            REG_STATUS_OFS: reg_rdata <= {26'h0, state_reg};
            REG_COUNT_OFS:  reg_rdata <= {16'h0, done_cnt_reg};
            REG_ADDR_OFS:   reg_rdata <= {8'h0, ptr_reg};
            default:        reg_rdata <= RDATA_NONE;
         endcase
      end else begin
         reg_rdata <= RDATA_NONE;
      end
   end

endmodule

// ==== fdpt_pkg.sv ====
// Constants, field layouts and state codes for the discovery parameter table block
package fdpt_pkg;

   // ------------------------------------------------------------
   // Link protocol
   // ------------------------------------------------------------
   localparam logic [7:0]  READ_DISCOVERY_TABLE_CMD = 8'h5A;  // Discovery read opcode
   localparam logic [2:0]  BIT_LAST                 = 3'h7;   // Last bit of a byte, MSB first
   localparam logic [1:0]  ADDR_BYTE_LAST           = 2'h2;   // Third address byte index
   localparam logic [15:0] TBL_HIGH_ZERO            = 16'h0000; // Table lives in low 256 bytes
   localparam logic [7:0]  BYTE_UNUSED              = 8'hFF;  // Unused positions read as ones

   // ------------------------------------------------------------
   // Header bytes
   // ------------------------------------------------------------
   localparam logic [7:0] HDR_SIG0        = 8'h53;
   localparam logic [7:0] HDR_SIG1        = 8'h46;
   localparam logic [7:0] HDR_SIG2        = 8'h44;
   localparam logic [7:0] HDR_SIG3        = 8'h50;
   localparam logic [7:0] HDR_REV_MINOR   = 8'h00;
   localparam logic [7:0] HDR_REV_MAJOR   = 8'h01;
   localparam logic [7:0] HDR_NUM_HDRS    = 8'h01;
   localparam logic [7:0] HDR_STD_ID      = 8'h00;
   localparam logic [7:0] HDR_BASIC_LEN   = 8'h09;
   localparam logic [7:0] PARAMETER_TABLE_POINTER = 8'h30;  // First byte of the basic table
   localparam logic [7:0] HDR_VND_LEN     = 8'h04;
   localparam logic [7:0] HDR_VND_PTR     = 8'h60;
   localparam logic [7:0] HDR_ZERO        = 8'h00;

   // ------------------------------------------------------------
   // Basic parameter table fields (first three doublewords)
   // ------------------------------------------------------------
   localparam logic [1:0] ERASE_4K_SUPPORT  = 2'h1;   // 01b: 4KB erase supported
   localparam logic       WRITE_GRAN_LARGE  = 1'b1;   // 64 bytes or more
   localparam logic       WREN_VOL_REQUIRED = 1'b0;   // No enable before volatile write
   localparam logic       WREN_OPCODE_SEL   = 1'b0;   // 0 selects 50h
   localparam logic [2:0] BYTE30_FIXED_TOP  = 3'h7;   // Always 111b
   localparam logic [7:0] ERASE_4K_OPCODE   = 8'h20;
   localparam logic       FR_112_SUPPORT    = 1'b1;
   localparam logic [1:0] ADDR_BYTES_MODE   = 2'h0;   // 3-byte addressing only
   localparam logic       DTR_SUPPORT       = 1'b0;
   localparam logic       FR_122_SUPPORT    = 1'b1;
   localparam logic       FR_144_SUPPORT    = 1'b1;
   localparam logic       FR_114_SUPPORT    = 1'b1;
   localparam logic       BIT_UNUSED        = 1'b1;
   localparam logic [4:0] FR_144_WAIT       = 5'h04;
   localparam logic [2:0] FR_144_MODE       = 3'h2;
   localparam logic [7:0] FR_144_OPCODE     = 8'hEB;
   localparam logic [4:0] FR_114_WAIT       = 5'h08;
   localparam logic [2:0] FR_114_MODE       = 3'h0;
   localparam logic [7:0] FR_114_OPCODE     = 8'h6B;

   // ------------------------------------------------------------
   // Software register map (byte addresses) and reset values
   // ------------------------------------------------------------
   localparam logic [7:0]  REG_CTRL_OFS   = 8'h00;
   localparam logic [7:0]  REG_STATUS_OFS = 8'h04;
   localparam logic [7:0]  REG_COUNT_OFS  = 8'h08;
   localparam logic [7:0]  REG_ADDR_OFS   = 8'h0C;
   localparam logic        CTRL_EN_RST    = 1'b1;
   localparam logic [31:0] RDATA_NONE     = 32'h0000_0000;

   // ------------------------------------------------------------
   // Link state machine, one-hot
   // ------------------------------------------------------------
   typedef enum logic [5:0] {
      FDPT_IDLE   = 6'b000001,
      FDPT_CMD    = 6'b000010,
      FDPT_ADDR   = 6'b000100,
      FDPT_DUMMY  = 6'b001000,
      FDPT_DATA   = 6'b010000,
      FDPT_IGNORE = 6'b100000
   } fdpt_state_t;

endpackage

// ==== fdpt_top_sva.sv ====
// Checker for the discovery parameter table responder ports
`timescale 1ns/100ps
module fdpt_top_sva (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // Link pins
   input wire logic        cs_n,
   input wire logic        so_oe,
   // Register port
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ------------------------------------------------------------
   // Link output enable
   // ------------------------------------------------------------
   // Raising chip select ends the output within the sync delay
   chk_oe_drop: assert property (
      $rose(cs_n) |-> ##[1:4] !so_oe) else $error("so_oe stayed up after cs_n rose");
   chk_oe_cs_high: assert property (
      cs_n [*4] |-> !so_oe) else $error("so_oe high while deselected");
   chk_oe_hold: assert property (
      so_oe && !cs_n |=> so_oe) else $error("so_oe dropped while selected");
   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   // Read data stand only in the cycle after the strobe
   chk_rdata_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("reg_rdata not zero");
   chk_status_idle: assert property (
      cs_n [*8] ##0 (reg_rd && reg_addr == 8'h04) |=> reg_rdata == 32'h1)
      else $error("state not idle after deselect");
   chk_ctrl_back: assert property (
      (reg_wr && reg_addr == 8'h00) ##1 (reg_rd && reg_addr == 8'h00)
      |=> reg_rdata[0] == $past(reg_wdata[0], 2)) else $error("enable readback wrong");
   chk_count_clear: assert property (
      (cs_n [*8] ##0 (reg_wr && reg_addr == 8'h08)) ##1 (reg_rd && reg_addr == 8'h08)
      |=> reg_rdata == 32'h0) else $error("count not cleared");
   chk_unmapped_zero: assert property (
      reg_rd && reg_addr == 8'h10 |=> reg_rdata == 32'h0) else $error("unmapped read not 0");
   // Main scenarios reached
   cov_data: cover property (so_oe);
   cov_abort: cover property (so_oe && $rose(cs_n));
   cov_clear: cover property (reg_wr && reg_addr == 8'h08);
endmodule
bind fdpt_top fdpt_top_sva fdpt_top_sva_inst (.clk(clk), .rstn(rstn), .cs_n(cs_n),
   .so_oe(so_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// ==== fdpt_host.sv ====
// Serial host model that reads the discovery table over the link
`timescale 1ns/100ps
module fdpt_host (
   // Link pins
   output logic      cs_n,
   output logic      sclk,
   output logic      si,
   input  wire logic so,
   input  wire logic so_oe
);
   localparam time HALF = 24;   // Half of the 48 ns link period
   logic [7:0] rx_bytes [16];   // Bytes returned in the last frame
   logic       oe_seen;         // Output enable seen in the last frame
   // Link idles deselected with the clock low
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end
   // Opcode, three address bytes, dummy byte, then n bytes in; clock stops outside frames
   task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int n);
      logic [39:0] hdr;
      hdr = {op, addr, 8'h00};
      oe_seen = 1'b0;
      cs_n = 1'b0;
      #HALF;
      for (int i = 39; i >= 0; i--) begin
         si = hdr[i];
         #HALF sclk = 1'b1;
         #HALF sclk = 1'b0;
      end
      for (int b = 0; b < n; b++) begin
         for (int i = 7; i >= 0; i--) begin
            si = ~si; // Don't-care input keeps moving so nothing relies on it
            #HALF sclk = 1'b1;
            // An undriven line shows the inverse of its last level, so a bit
            // taken while the output enable is low cannot pass by accident
            rx_bytes[b][i] = so_oe ? so : ~so;
            oe_seen |= so_oe;
            #HALF sclk = 1'b0;
         end
      end
      #HALF cs_n = 1'b1;
      si = ~si;
      #(4 * HALF);
   endtask
endmodule

// ==== tb.sv ====
// Self-checking bench for the discovery parameter table responder
`timescale 1ns/100ps
module tb;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        clk, rstn, cs_n, sclk, si, so, so_oe;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd_val;
   logic        reg_wr, reg_rd;
   int          mismatches = 0;
   int          check_count = 0;
   // Expected bytes from 30h upward
   logic [7:0]  exp_tbl [12] = '{8'hE5, 8'h20, 8'hF1, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                 8'h44, 8'hEB, 8'h08, 8'h6B};
   fdpt_top fdpt_top_inst (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .si(si),
      .so(so), .so_oe(so_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   fdpt_host fdpt_host_inst (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe));
   // ------------------------------------------------------------
   // Shared tasks; bus tasks start and end just after a rising edge
   // ------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      // Read data stand in the next cycle; take them at its closing edge
      @(posedge clk);
      d = reg_rdata;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Whole first three doublewords in one burst
   task automatic t_table();
      logic [7:0] rx [16];
      fdpt_host_inst.frame(8'h5A, 24'h000030, 12);
      rx = fdpt_host_inst.rx_bytes;
      chk("oe", {31'h0, fdpt_host_inst.oe_seen}, 32'h1);
      // Erase, status enable, address width and read-mode flags
      for (int i = 0; i < 4; i++)
         chk("tbl", 32'(rx[i]), 32'(exp_tbl[i]));
      // Density filler, then wait, mode and opcode fields
      for (int i = 4; i < 12; i++)
         chk("tbl", 32'(rx[i]), 32'(exp_tbl[i]));
      $display("test table done");
   endtask
   // Header pointer to the table, then completed-read count
   task automatic t_header();
      fdpt_host_inst.frame(8'h5A, 24'h00000C, 4);
      chk("ptp0", {24'h0, fdpt_host_inst.rx_bytes[0]}, 32'h30);
      chk("ptp1", {24'h0, fdpt_host_inst.rx_bytes[1]}, 32'h00);
      chk("ptp2", {24'h0, fdpt_host_inst.rx_bytes[2]}, 32'h00);
      chk("ptp3", {24'h0, fdpt_host_inst.rx_bytes[3]}, 32'hFF);
      @(posedge clk);
      rd(8'h08, rd_val);
      chk("count", rd_val, 32'h2);
      $display("test header done");
   endtask
   // Foreign opcode and disabled block both stay silent
   task automatic t_refuse();
      fdpt_host_inst.frame(8'h03, 24'h000030, 2);
      chk("oe op", {31'h0, fdpt_host_inst.oe_seen}, 32'h0);
      @(posedge clk);
      wr(8'h00, 32'h0);
      fdpt_host_inst.frame(8'h5A, 24'h000030, 2);
      chk("oe off", {31'h0, fdpt_host_inst.oe_seen}, 32'h0);
      @(posedge clk);
      wr(8'h00, 32'h1);
      rd(8'h00, rd_val);
      chk("ctrl", rd_val, 32'h1);
      rd(8'h08, rd_val);
      chk("count", rd_val, 32'h2);
      $display("test refuse done");
   endtask
   // Early deselect, count clear, unmapped and out-of-table reads
   task automatic t_abort();
      fdpt_host_inst.frame(8'h5A, 24'h000032, 1);
      chk("b32", {24'h0, fdpt_host_inst.rx_bytes[0]}, 32'hF1);
      @(posedge clk);
      rd(8'h04, rd_val);
      chk("state", rd_val, 32'h1);
      rd(8'h08, rd_val);
      chk("count", rd_val, 32'h3);
      wr(8'h08, 32'h0);
      rd(8'h08, rd_val);
      chk("cleared", rd_val, 32'h0);
      rd(8'h10, rd_val);
      chk("unmapped", rd_val, 32'h0);
      fdpt_host_inst.frame(8'h5A, 24'h000100, 1);
      chk("b100", {24'h0, fdpt_host_inst.rx_bytes[0]}, 32'hFF);
      $display("test abort done");
   endtask
   // ------------------------------------------------------------
   // Clock, reset, sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      rstn = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      t_table();
      t_header();
      t_refuse();
      t_abort();
      wrap_up();
   end
   // A hang counts as a mismatch and ends the run
   initial begin
      #200000;
      mismatches++;
      wrap_up();
   end
endmodule
